//--- hw/prot_ctrl_pkg.sv
package prot_ctrl_pkg;
    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [15:0] OFF_CAP = 16'hed90;
    localparam logic [15:0] OFF_CTRL = 16'hed94;
    localparam logic [15:0] OFF_SEL = 16'hed98;
    localparam logic [15:0] OFF_BASE = 16'hed9c;
    localparam logic [15:0] OFF_ATTR = 16'heda0;
    localparam logic [15:0] OFF_ISTS = 16'hedb0;
    localparam logic [15:0] OFF_IMSK = 16'hedb4;

    // ****************************************************************
    // fields and fixed values
    // ****************************************************************
    localparam logic [7:0] REGION_COUNT = 8'h08;
    localparam logic [7:0] INSTR_REGION_COUNT = 8'h00;
    localparam logic SPLIT_MAP = 1'b0;
    localparam int CTRL_EN = 0;
    localparam int CTRL_HF = 1;
    localparam int CTRL_BG = 2;
    localparam int BASE_VALID = 4;
    localparam int ATTR_XN = 28;
    localparam logic [3:0] SEL_MAX = 4'h7;
    localparam logic [4:0] SIZE_MIN = 5'h07;
    localparam int NREG = 8;
    localparam int EV_FAULT = 0;
    localparam int EV_BADSEL = 1;
    localparam int NEV = 2;

    typedef struct packed {
        logic enable;
        logic bg_en;
        logic hf_prot;
        logic [3:0] sel;
        logic [NREG-1:0][23:0] base;
        logic [NREG-1:0][15:0] attrs;
        logic [NREG-1:0][7:0] srd;
        logic [NREG-1:0][4:0] size;
        logic [NREG-1:0] ren;
        logic ph_wr;
        logic [15:0] ph_addr;
        logic [31:0] rdata;
        logic fault;
        logic done;
        logic [NEV-1:0] sts;
        logic [NEV-1:0] msk;
    } state_t;
endpackage

//--- hw/prot_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] capability reports eight regions, read-only
// [R2] instruction region count reads zero
// [R3] split-map bit reads zero
// [R4] background enable ignored while protection off
// [R5] enabled, no background: unmatched access faults
// [R6] background on: privileged misses use default map
// [R7] enabled regions override background region
// [R8] software keeps handler bit clear when disabled
// [R9] handler bit clear: no checks in handlers
// [R10] handler bit set: checks continue in handlers
// [R11] protection off: default map only
// [R12] control bits reset to zero
// [R13] selector picks region, resets to zero
// [R14] software writes only selector values 0-7
// [R15] valid base write also loads selector
// [R16] region size is two to size plus one
// [R17] reserved bits read zero, ignore writes
module prot_ctrl
    import prot_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic acc_priv,
    input wire logic acc_fetch,
    input wire logic acc_in_handler,
    output logic acc_done,
    output logic acc_fault,
    output logic irq
);
    state_t st_ff;
    state_t nxt_st;

    // ****************************************************************
    // region match
    // ****************************************************************
    function automatic logic region_hit(input logic [31:0] a,
        input logic [23:0] b, input logic [4:0] sz,
        input logic [7:0] sd, input logic en);
        logic [4:0] s;
        logic [31:0] m;
        logic [2:0] sub;
        // sizes below the minimum are treated as the minimum
        s = (sz < SIZE_MIN) ? SIZE_MIN : sz;
        // region spans 2^(size+1) bytes
        m = ~((32'h0000_0001 << ({1'b0, s} + 6'h01)) - 32'h0000_0001); // [R16]
        sub = 3'(a >> ({1'b0, s} - 6'h02));
        return en && ((a & m) == ({b, 8'h00} & m)) && !sd[sub];
    endfunction

    logic [NREG-1:0] hits;
    logic any_hit;
    logic hit_xn;
    logic checking;
    logic rd_ap;
    logic [2:0] widx;

    always_comb begin
        hits = '0;
        hit_xn = 1'b0;
        for (int i = 0; i < NREG; i++) begin
            hits[i] = region_hit(acc_addr, st_ff.base[i], st_ff.size[i],
                st_ff.srd[i], st_ff.ren[i]);
            // higher numbered region wins, background is below all
            if (hits[i]) begin
                hit_xn = st_ff.attrs[i][ATTR_XN-16]; // [R7]
            end
        end
        any_hit = |hits;
        // handlers bypass checks unless the handler bit is set
        checking = st_ff.enable
            && !(acc_in_handler && !st_ff.hf_prot); // [R9] [R10] [R11]
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        widx = st_ff.sel[2:0];
        rd_ap = hsel && htrans[1] && hready && !hwrite;
        // data phase writes: reserved bits are simply not stored
        if (st_ff.ph_wr) begin
            unique case (st_ff.ph_addr)
                OFF_CTRL: begin
                    nxt_st.enable = hwdata[CTRL_EN];
                    nxt_st.hf_prot = hwdata[CTRL_HF];
                    nxt_st.bg_en = hwdata[CTRL_BG]; // [R17]
                end
                OFF_SEL: begin
                    nxt_st.sel = hwdata[3:0]; // [R13]
                end
                OFF_BASE: begin
                    if (hwdata[BASE_VALID]) begin
                        nxt_st.sel = hwdata[3:0]; // [R15]
                        widx = hwdata[2:0];
                    end
                    nxt_st.base[widx] = hwdata[31:8];
                end
                OFF_ATTR: begin
                    nxt_st.attrs[widx] = hwdata[31:16];
                    nxt_st.srd[widx] = hwdata[15:8];
                    nxt_st.size[widx] = hwdata[5:1];
                    nxt_st.ren[widx] = hwdata[0];
                end
                OFF_ISTS: begin
                    nxt_st.sts = st_ff.sts & ~hwdata[NEV-1:0];
                end
                OFF_IMSK: begin
                    nxt_st.msk = hwdata[NEV-1:0];
                end
                default: begin
                end
            endcase
            // out of range selector is flagged, set wins over clear
            if ((st_ff.ph_addr == OFF_SEL
                || (st_ff.ph_addr == OFF_BASE && hwdata[BASE_VALID]))
                && hwdata[3:0] > SEL_MAX) begin
                nxt_st.sts[EV_BADSEL] = 1'b1; // [R14]
            end
        end
        // access check
        nxt_st.done = acc_valid;
        nxt_st.fault = 1'b0;
        if (acc_valid && checking) begin
            if (any_hit) begin
                nxt_st.fault = hit_xn && acc_fetch; // [R7]
            end else begin
                // background map only for privileged accesses
                nxt_st.fault = !(acc_priv && st_ff.bg_en); // [R4] [R5] [R6]
            end
        end
        if (nxt_st.fault) begin
            nxt_st.sts[EV_FAULT] = 1'b1;
        end
        // address phase, read mux sees this cycle's write
        nxt_st.ph_wr = hsel && htrans[1] && hready && hwrite;
        nxt_st.ph_addr = haddr[15:0];
        nxt_st.rdata = '0;
        if (rd_ap) begin
            unique case (haddr[15:0])
                OFF_CAP: begin
                    nxt_st.rdata = {8'h00, INSTR_REGION_COUNT,
                        REGION_COUNT, 7'h00, SPLIT_MAP}; // [R1] [R2] [R3]
                end
                OFF_CTRL: begin
                    nxt_st.rdata = {29'h0000_0000, nxt_st.bg_en,
                        nxt_st.hf_prot, nxt_st.enable}; // [R17] [R12]
                end
                OFF_SEL: begin
                    nxt_st.rdata = {28'h000_0000, nxt_st.sel};
                end
                OFF_BASE: begin
                    nxt_st.rdata = {nxt_st.base[nxt_st.sel[2:0]],
                        4'h0, nxt_st.sel};
                end
                OFF_ATTR: begin
                    nxt_st.rdata = {nxt_st.attrs[nxt_st.sel[2:0]],
                        nxt_st.srd[nxt_st.sel[2:0]], 2'h0,
                        nxt_st.size[nxt_st.sel[2:0]],
                        nxt_st.ren[nxt_st.sel[2:0]]};
                end
                OFF_ISTS: begin
                    nxt_st.rdata = {30'h0000_0000, nxt_st.sts};
                end
                OFF_IMSK: begin
                    nxt_st.rdata = {30'h0000_0000, nxt_st.msk};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff <= '0; // [R12] [R13]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign acc_done = st_ff.done;
    assign acc_fault = st_ff.fault;
    assign irq = |(st_ff.sts & st_ff.msk);

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence cap_rd_s;
        hsel && htrans[1] && hready && !hwrite && haddr[15:0] == OFF_CAP;
    endsequence
    sequence ctrl_rd_s;
        hsel && htrans[1] && hready && !hwrite && haddr[15:0] == OFF_CTRL;
    endsequence
    sequence base_wr_s;
        hsel && htrans[1] && hready && hwrite && haddr[15:0] == OFF_BASE;
    endsequence
    sequence sel_wr_s;
        hsel && htrans[1] && hready && hwrite && haddr[15:0] == OFF_SEL;
    endsequence
    sequence sel_rd_s;
        hsel && htrans[1] && hready && !hwrite && haddr[15:0] == OFF_SEL;
    endsequence

    cap_value_a: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
        cap_rd_s |=> hrdata == 32'h0000_0800)
        else $error("capability read wrong");

    cap_fixed_a: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
        cap_rd_s |=> hrdata[23:16] == 8'h00 && hrdata[0] == 1'b0) // [R3]
        else $error("capability fixed fields wrong");

    ctrl_rsvd_a: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
        ctrl_rd_s |=> hrdata[31:3] == 29'h0000_0000)
        else $error("control reserved bits nonzero");

    sel_rsvd_a: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
        sel_rd_s |=> hrdata[31:4] == 28'h000_0000)
        else $error("selector reserved bits nonzero");

    reset_clear_a: assert property (@(posedge sys_clk) // [R12]
        reset |=> !st_ff.enable && !st_ff.bg_en && !st_ff.hf_prot
            && st_ff.sel == 4'h0 && !acc_fault)
        else $error("control not cleared by reset");

    sel_load_a: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
        sel_wr_s ##1 !reset
            |=> st_ff.sel == $past(hwdata[3:0]))
        else $error("selector write not stored");

    // out of range values are kept but flagged for software
    badsel_flag_a: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
        sel_wr_s ##1 hwdata[3:0] > SEL_MAX
            |=> st_ff.sts[EV_BADSEL])
        else $error("bad selector not flagged");

    base_sel_a: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
        base_wr_s ##1 (hwdata[BASE_VALID] && !reset)
            |=> st_ff.sel == $past(hwdata[3:0]))
        else $error("selector not loaded by base write");

    base_keep_a: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
        base_wr_s ##1 !hwdata[BASE_VALID] |=> $stable(st_ff.sel))
        else $error("selector changed by base write");

    // ****************************************************************
    // access checks
    // ****************************************************************
    done_pulse_a: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
        acc_valid |=> acc_done)
        else $error("access not answered");

    off_nofault_a: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
        acc_valid && !st_ff.enable |=> acc_done && !acc_fault)
        else $error("fault while protection off");

    bg_ignored_a: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
        acc_valid && !st_ff.enable && st_ff.bg_en |=> !acc_fault)
        else $error("background bit used while off");

    miss_fault_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
        acc_valid && st_ff.enable && !st_ff.bg_en && !acc_in_handler
            && !any_hit |=> acc_fault ##1 irq || !st_ff.msk[EV_FAULT])
        else $error("unmatched access did not fault");

    bg_priv_a: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
        acc_valid && st_ff.enable && st_ff.bg_en && acc_priv && !any_hit
            |=> !acc_fault)
        else $error("privileged background access faulted");

    // while checking is on (protection on, not a handler with the handler bit clear), unprivileged code never falls back to the default map
    unpriv_bg_a: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
        acc_valid && st_ff.enable && st_ff.bg_en && !acc_priv
            && !acc_in_handler && !any_hit |=> acc_fault)
        else $error("unprivileged background access passed");

    hf_bypass_a: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
        acc_valid && acc_in_handler && !st_ff.hf_prot |=> !acc_fault)
        else $error("handler access checked");

    hf_keep_a: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
        acc_valid && acc_in_handler && st_ff.enable && st_ff.hf_prot
            && !any_hit && !acc_priv |=> acc_fault)
        else $error("handler access not checked");

    region_prio_a: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
        acc_valid && st_ff.enable && !acc_in_handler && any_hit && hit_xn
            && acc_fetch && acc_priv && st_ff.bg_en |=> acc_fault)
        else $error("background overrode a region");
endmodule // prot_ctrl

//--- test/core_model.sv
`timescale 1ns/1ps
// ****************************************
// processor core issuing checked accesses
// ****************************************
module core_model (
    input wire logic sys_clk,
    input wire logic acc_done,
    input wire logic acc_fault,
    output logic acc_valid,
    output logic [31:0] acc_addr,
    output logic acc_priv,
    output logic acc_fetch,
    output logic acc_in_handler
);
    initial begin
        acc_valid = 1'b0;
        acc_addr = 32'h0000_0000;
        acc_priv = 1'b0;
        acc_fetch = 1'b0;
        acc_in_handler = 1'b0;
    end

    // gap lets the core be slow; result is x if no answer comes
    task automatic access(input logic [31:0] a, input logic p,
                          input logic f, input logic h, input int gap,
                          output logic flt);
        int n;
        repeat (gap) @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_priv <= p;
        acc_fetch <= f;
        acc_in_handler <= h;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        // stale address would hide a design that samples late
        acc_addr <= ~a;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (acc_done !== 1'b1 && n < 4);
        flt = (acc_done === 1'b1) ? acc_fault : 1'bx;
    endtask
endmodule // core_model

//--- test/tb_prot_ctrl.sv
`timescale 1ns/1ps
module tb_prot_ctrl import prot_ctrl_pkg::*;;
    logic sys_clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, acc_addr, rd, rnd, a;
    logic [1:0] htrans;
    logic acc_valid, acc_priv, acc_fetch, acc_in_handler;
    logic acc_done, acc_fault, flt;
    logic [7:0] ctrl_tab [6] = '{8'h00, 8'h04, 8'h01, 8'h05, 8'h03, 8'h07};
    int n_errors, n_compared, cycles;

    assign hready = hreadyout;

    prot_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_priv(acc_priv), .acc_fetch(acc_fetch),
        .acc_in_handler(acc_in_handler), .acc_done(acc_done),
        .acc_fault(acc_fault), .irq(irq));

    core_model core (.sys_clk(sys_clk), .acc_done(acc_done),
        .acc_fault(acc_fault), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_priv(acc_priv), .acc_fetch(acc_fetch),
        .acc_in_handler(acc_in_handler));

    // ****************************************
    // helpers
    // ****************************************
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [15:0] ad,
                       input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {16'h0000, ad};
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // one region: 256 bytes at 0x2000_0000, fetches barred
    function automatic logic exp_fault(input logic [2:0] c,
        input logic [31:0] ad, input logic p, input logic f, input logic h);
        if (!c[0] || (h && !c[1]))
            return 1'b0;
        if (ad[31:8] == 24'h20_0000)
            return f;
        return !(p && c[2]);
    endfunction

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_errors++;
            conclude();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        rnd = 32'h1286_73e4;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(0, OFF_CAP, 0, rd); chk("cap", rd, 32'h0000_0800);
        bus(0, OFF_CTRL, 0, rd); chk("ctrl reset", rd, 0);
        bus(0, OFF_SEL, 0, rd); chk("sel reset", rd, 0);
        bus(1, OFF_CAP, 32'hffff_ffff, rd);
        bus(0, OFF_CAP, 0, rd); chk("cap ro", rd, 32'h0000_0800);
        bus(1, OFF_CTRL, 32'hffff_fffd, rd);
        bus(0, OFF_CTRL, 0, rd); chk("ctrl rsvd", rd, 5);
        bus(1, OFF_SEL, 32'hffff_fff6, rd);
        bus(0, OFF_SEL, 0, rd); chk("sel rsvd", rd, 6);
        bus(0, 16'hed80, 0, rd); chk("unmapped", rd, 0);
        chk("hresp", {31'd0, hresp}, 0);
        chk("hreadyout", {31'd0, hreadyout}, 1);
        bus(1, OFF_BASE, 32'h2000_0013, rd);
        bus(0, OFF_SEL, 0, rd); chk("sel valid", rd, 3);
        bus(1, OFF_BASE, 32'h2000_0005, rd);
        bus(0, OFF_SEL, 0, rd); chk("sel kept", rd, 3);
        bus(1, OFF_ATTR, 32'h1000_000f, rd);
        bus(0, OFF_BASE, 0, rd); chk("base", rd, 32'h2000_0003);
        // every control setting that software may legally use
        for (int i = 0; i < 6; i++) begin
            bus(1, OFF_CTRL, {24'h0, ctrl_tab[i]}, rd);
            repeat (16) begin
                rnd = lfsr(rnd);
                a = rnd[31] ? rnd : 32'h2000_0000 | (rnd & 32'h0000_01ff);
                core.access(a, rnd[0], rnd[1], rnd[2], rnd[4], flt);
                chk("fault", flt, exp_fault(ctrl_tab[i][2:0], a, rnd[0],
                    rnd[1], rnd[2]));
            end
        end
        core.access(32'h2000_00ff, 1, 1, 0, 0, flt);
        chk("region over bg", flt, 1);
        core.access(32'h2000_0100, 1, 0, 0, 0, flt);
        chk("past end priv", flt, 0);
        core.access(32'h2000_0100, 0, 0, 0, 1, flt);
        chk("past end user", flt, 1);
        bus(1, OFF_ISTS, 32'h0000_0003, rd);
        bus(0, OFF_ISTS, 0, rd); chk("sts clear", rd, 0);
        bus(1, OFF_CTRL, 32'h0000_0001, rd);
        core.access(32'h4000_0000, 1, 0, 0, 0, flt);
        bus(0, OFF_ISTS, 0, rd); chk("sts fault", rd, 1);
        chk("irq masked", {31'd0, irq}, 0);
        bus(1, OFF_IMSK, 32'h0000_0001, rd);
        bus(0, OFF_IMSK, 0, rd); chk("irq on", {31'd0, irq}, 1);
        bus(1, OFF_ISTS, 32'h0000_0001, rd);
        bus(0, OFF_IMSK, 0, rd); chk("irq off", {31'd0, irq}, 0);
        // out of range selector is kept but flagged in the status
        bus(1, OFF_SEL, 32'h0000_0009, rd);
        bus(0, OFF_ISTS, 0, rd); chk("sts badsel", rd, 2);
        conclude();
    end
endmodule // tb_prot_ctrl
